// ==== logic/config_loader_pkg.sv ====
// Constants, timing counts and state encoding for the parallel config loader
package config_loader_pkg;

   // Data path widths
   localparam int WORD_W      = 16;       // Wide mode data lines
   localparam int NARROW_W    = 8;        // Narrow mode data lines
   localparam int FIFO_DEPTH  = 32;       // Words buffered toward the sink

   // Configuration image
   localparam int IMAGE_WORDS = 256;      // Words in one complete image
   localparam int COUNT_W     = 9;        // Holds 0..IMAGE_WORDS
   localparam logic [COUNT_W-1:0] IMAGE_LAST_COUNT = 9'h100;
   localparam int OPT_INIT_BIT = 0;       // Init-complete enable, word 0

   // Falling edges wanted after the last word (own fall plus two more)
   localparam int FALL_EDGES  = 2;
   localparam logic [1:0] FALL_TARGET = 2'h3;

   // Power-on-reset delay, expressed in system clock cycles
   localparam int CLK_KHZ       = 25000;  // clk_sys rate
   localparam int POR_DELAY_US  = 100;    // Least time status stays low
   localparam int POR_CYCLES    = (POR_DELAY_US * CLK_KHZ + 999) / 1000;
   localparam int POR_W         = 12;
   localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_CYCLES - 1);

   // Loader sequence, one-hot
   typedef enum logic [5:0] {
      ST_POR     = 6'h01,
      ST_RESTART = 6'h02,
      ST_LOAD    = 6'h04,
      ST_INIT    = 6'h08,
      ST_USER    = 6'h10,
      ST_ERROR   = 6'h20
   } loader_state_type;

endpackage

// ==== logic/config_fifo.sv ====
// Flip-flop FIFO with valid/ready handshakes on both sides
module config_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             resetn,
   input  wire logic             flush,
   // Filling side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // Draining side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);

   localparam int PTR_W = $clog2(DEPTH);

   logic [WIDTH-1:0] store [DEPTH];      // Word storage
   logic [PTR_W-1:0] wrPtr;              // Next slot to fill
   logic [PTR_W-1:0] rdPtr;              // Next slot to drain
   logic [PTR_W:0]   fill;               // Words held
   logic             doPush;
   logic             doPop;

   // Full and empty straight from the fill level
   assign inReady  = (fill != (PTR_W+1)'(DEPTH));
   assign outValid = (fill != '0);
   assign outData  = store[rdPtr];
   assign doPush   = inValid && inReady;
   assign doPop    = outValid && outReady;

   // Storage write, no reset needed on data
   always_ff @(posedge clk_sys) begin
      if (doPush) begin
         store[wrPtr] <= inData;
      end
   end

   // Pointers and level; flush empties on restart
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wrPtr <= '0;
         rdPtr <= '0;
         fill  <= '0;
      end else if (flush) begin
         wrPtr <= '0;
         rdPtr <= '0;
         fill  <= '0;
      end else begin
         if (doPush) begin
            wrPtr <= (wrPtr == PTR_W'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
         end
         if (doPop) begin
            rdPtr <= (rdPtr == PTR_W'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
         end
         // Simultaneous push and pop leaves the level alone
         if (doPush && !doPop) begin
            fill <= fill + 1'b1;
         end else if (doPop && !doPush) begin
            fill <= fill - 1'b1;
         end
      end
   end

endmodule

// ==== logic/parallel_config_loader.sv ====
// Device-side fast parallel configuration loader with load-clock domain
//
// Functional notes
// - Restart request low abandons user mode, reloads.
// - Ready status held low for power-on delay.
// - Load-complete low from power-up through loading.
// - Load clock ignored once configuration finished.
// - Wide mode uses 16 lines, narrow eight.
// - Load-complete rises only after every word received.
// - Init-complete driven low once option bit loaded.
// - One load clock cycle carries one word.
module parallel_config_loader (
   // System clock and reset
   input  wire logic                               clk_sys,
   input  wire logic                               resetn,
   // Host link pins
   input  wire logic                               loadClock,
   input  wire logic [config_loader_pkg::WORD_W-1:0] loadData,
   input  wire logic                               restartRequestN,
   input  wire logic                               wideMode,
   output logic                                    readyStatusN,
   output logic                                    loadComplete,
   output logic                                    initComplete,
   output logic                                    initCompleteEn,
   output logic                                    userIoEnable,
   // Configuration word sink
   output logic [config_loader_pkg::WORD_W-1:0]    cfgWord,
   output logic                                    cfgValid,
   input  wire logic                               cfgReady
);
   import config_loader_pkg::*;

   // ---------------- Load clock domain ----------------
   logic [WORD_W-1:0]  slot [2];         // Ping-pong word holders
   logic               wrSel;            // Slot written next
   logic               wrToggle;         // Flips once per captured word
   logic [COUNT_W-1:0] linkCount;        // Words captured this cycle
   logic [1:0]         fallCount;        // Falling edges after last word
   logic               fallsSeen;        // Enough falls for init

   // ---------------- System clock domain ----------------
   loader_state_type   state;            // Loader sequence
   loader_state_type   next_state;
   logic [POR_W-1:0]   porCount;         // Power-on delay timer
   logic               linkResetN;       // Holds link logic in reset
   logic               restartMeta;      // Restart pin, first stage
   logic               restartSync;      // Restart pin, usable
   logic               wideMeta;         // Width strap, first stage
   logic               wideSync;         // Width strap, usable
   logic               togMeta;          // Word toggle, first stage
   logic               togSync;          // Word toggle, usable
   logic               togSeen;          // Last toggle value handled
   logic               fallMeta;         // Falls flag, first stage
   logic               fallSync;         // Falls flag, usable
   logic               rdSel;            // Slot read next
   logic [COUNT_W-1:0] pushCount;        // Words pushed into the FIFO
   logic               newWord;          // A captured word is waiting
   logic [WORD_W-1:0]  maskedWord;       // Word after width selection
   logic               fifoInReady;
   logic               fifoOutValid;
   logic [WORD_W-1:0]  fifoOutData;
   logic               fifoPop;
   logic               overflow;         // Word arrived with FIFO full
   logic               imageAllIn;       // Every word pushed
   logic               drained;          // Every word handed to sink

   // Narrow mode keeps only the low lines
   function automatic logic [WORD_W-1:0] selectWidth(
      input logic [WORD_W-1:0] raw,
      input logic              wide
   );
      logic [WORD_W-1:0] result;
      result = raw;
      if (!wide) begin
         result = {{(WORD_W-NARROW_W){1'b0}}, raw[NARROW_W-1:0]};
      end
      return result;
   endfunction

   // ==================================================================
   // Load clock domain
   // ==================================================================

   // Capture one word per rising edge until the image is complete.
   // Beyond the last word the clock is ignored for data.
   always_ff @(posedge loadClock or negedge linkResetN) begin
      if (!linkResetN) begin
         wrSel     <= 1'b0;
         wrToggle  <= 1'b0;
         linkCount <= '0;
      end else if (linkCount != IMAGE_LAST_COUNT) begin
         wrSel     <= ~wrSel;
         wrToggle  <= ~wrToggle;
         linkCount <= linkCount + 1'b1;
      end
   end

   // Slot storage; data lines only meaningful at this edge
   always_ff @(posedge loadClock) begin
      if (linkResetN && linkCount != IMAGE_LAST_COUNT) begin
         slot[wrSel] <= loadData;
      end
   end

   // Count falls after the last word. The last word's own fall always
   // comes before load-complete can rise, so it is counted as extra.
   always_ff @(negedge loadClock or negedge linkResetN) begin
      if (!linkResetN) begin
         fallCount <= '0;
         fallsSeen <= 1'b0;
      end else if (linkCount == IMAGE_LAST_COUNT && !fallsSeen) begin
         fallCount <= fallCount + 1'b1;
         fallsSeen <= (fallCount == FALL_TARGET - 2'h1);
      end
   end

   // ==================================================================
   // System clock domain
   // ==================================================================

   // Two-stage synchronisers for pins and link-domain levels
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         restartMeta <= 1'b1;
         restartSync <= 1'b1;
         wideMeta    <= 1'b0;
         wideSync    <= 1'b0;
         togMeta     <= 1'b0;
         togSync     <= 1'b0;
         fallMeta    <= 1'b0;
         fallSync    <= 1'b0;
      end else begin
         restartMeta <= restartRequestN;
         restartSync <= restartMeta;
         wideMeta    <= wideMode;
         wideSync    <= wideMeta;
         togMeta     <= wrToggle;
         togSync     <= togMeta;
         fallMeta    <= fallsSeen;
         fallSync    <= fallMeta;
      end
   end

   // Link reset follows the sequence: released only once ready. The
   // release lands before the host may clock, so no link sync needed.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         linkResetN <= 1'b0;
      end else begin
         linkResetN <= (next_state == ST_LOAD) || (next_state == ST_INIT)
                       || (next_state == ST_USER);
      end
   end

   // Power-on delay timer
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         porCount <= '0;
      end else if (state == ST_POR && porCount != POR_LAST) begin
         porCount <= porCount + 1'b1;
      end
   end

   // A new word shows as a toggle mismatch
   assign newWord    = (togSync != togSeen);
   assign maskedWord = selectWidth(slot[rdSel], wideSync);
   assign overflow   = newWord && !fifoInReady && state == ST_LOAD;
   assign imageAllIn = (pushCount == IMAGE_LAST_COUNT);
   assign drained    = imageAllIn && !fifoOutValid && !cfgValid;

   // Word intake from the ping-pong slots
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         togSeen   <= 1'b0;
         rdSel     <= 1'b0;
         pushCount <= '0;
      end else if (state != ST_LOAD) begin
         // Link logic restarts from reset before each load; match its fresh values
         togSeen   <= 1'b0;
         rdSel     <= 1'b0;
         pushCount <= '0;
      end else if (newWord && fifoInReady) begin
         togSeen   <= ~togSeen;
         rdSel     <= ~rdSel;
         pushCount <= pushCount + 1'b1;
      end
   end

   // Buffer between capture and the sink; a stalled sink backs it up
   config_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys  (clk_sys),
      .resetn   (resetn),
      .flush    (state != ST_LOAD),
      .inValid  (newWord && state == ST_LOAD),
      .inReady  (fifoInReady),
      .inData   (maskedWord),
      .outValid (fifoOutValid),
      .outReady (fifoPop),
      .outData  (fifoOutData)
   );

   // Output stage refills when empty or when the sink takes a word
   assign fifoPop = fifoOutValid && (!cfgValid || cfgReady);

   // Registered sink outputs
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cfgValid <= 1'b0;
         cfgWord  <= '0;
      end else if (state != ST_LOAD) begin
         cfgValid <= 1'b0;
      end else if (fifoPop) begin
         cfgValid <= 1'b1;
         cfgWord  <= fifoOutData;
      end else if (cfgReady) begin
         cfgValid <= 1'b0;
      end
   end

   // Sequence decisions; restart low wins from any state except ST_POR, which first waits out the power-on delay
   always_comb begin
      next_state = state;
      case (state)
         ST_POR: begin
            if (porCount == POR_LAST && restartSync) begin
               next_state = ST_LOAD;
            end else if (porCount == POR_LAST) begin
               next_state = ST_RESTART;
            end
         end
         ST_RESTART: begin
            if (restartSync) begin
               next_state = ST_LOAD;
            end
         end
         ST_LOAD: begin
            if (!restartSync) begin
               next_state = ST_RESTART;
            end else if (overflow) begin
               next_state = ST_ERROR;
            end else if (drained) begin
               next_state = ST_INIT;
            end
         end
         ST_INIT: begin
            if (!restartSync) begin
               next_state = ST_RESTART;
            end else if (fallSync) begin
               next_state = ST_USER;
            end
         end
         ST_USER: begin
            if (!restartSync) begin
               next_state = ST_RESTART;
            end
         end
         ST_ERROR: begin
            if (!restartSync) begin
               next_state = ST_RESTART;
            end
         end
         default: begin
            next_state = ST_POR;
         end
      endcase
   end

   // Sequence register
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state <= ST_POR;
      end else begin
         state <= next_state;
      end
   end

   // Status pins follow the coming state so they are pure flops
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         readyStatusN <= 1'b0;
         loadComplete <= 1'b0;
         userIoEnable <= 1'b0;
      end else begin
         readyStatusN <= (next_state == ST_LOAD) ||
                         (next_state == ST_INIT) ||
                         (next_state == ST_USER);
         loadComplete <= (next_state == ST_INIT) ||
                         (next_state == ST_USER);
         userIoEnable <= (next_state == ST_USER);
      end
   end

   // Init-complete: enabled by option bit in the first word, low
   // from that moment until user mode is entered
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         initCompleteEn <= 1'b0;
         initComplete   <= 1'b1;
      end else if (next_state == ST_RESTART || next_state == ST_POR) begin
         initCompleteEn <= 1'b0;
         initComplete   <= 1'b1;
      end else if (state == ST_LOAD && newWord && fifoInReady
                   && pushCount == '0 && maskedWord[OPT_INIT_BIT]) begin
         initCompleteEn <= 1'b1;
         initComplete   <= 1'b0;
      end else if (next_state == ST_USER) begin
         initComplete   <= 1'b1;
      end
   end

endmodule

// ==== dv/parallel_config_loader_properties.sv ====
// Port-level concurrent checks for the parallel config loader
module load_checker (
   // Clock and reset
   input wire logic                                   clk_sys,
   input wire logic                                   resetn,
   // Host link pins
   input wire logic                                   loadClock,
   input wire logic [config_loader_pkg::WORD_W-1:0]   loadData,
   input wire logic                                   restartRequestN,
   input wire logic                                   wideMode,
   input wire logic                                   readyStatusN,
   input wire logic                                   loadComplete,
   input wire logic                                   initComplete,
   input wire logic                                   initCompleteEn,
   input wire logic                                   userIoEnable,
   // Sink side
   input wire logic [config_loader_pkg::WORD_W-1:0]   cfgWord,
   input wire logic                                   cfgValid,
   input wire logic                                   cfgReady
);
   timeunit 1ns;
   timeprecision 1ps;
   import config_loader_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   logic [POR_W-1:0]   porCount;   // Cycles since reset release, saturating
   logic [COUNT_W-1:0] wordCount;  // Words taken by the sink in this load

   // Power-on timer seen from outside
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
         porCount <= '0;
      else if (porCount != '1)
         porCount <= porCount + 1'b1;
   end

   // Sink handshakes; a restart starts a fresh image
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
         wordCount <= '0;
      else if (!restartRequestN)
         wordCount <= '0;
      else if (cfgValid && cfgReady)
         wordCount <= wordCount + 1'b1;
   end

   sequence restartHeld;
      (!restartRequestN) [*3];
   endsequence
   sequence linkQuiet;
      !readyStatusN && !loadComplete && !userIoEnable;
   endsequence

   por_hold_low_a: assert property (porCount < POR_LAST |-> !readyStatusN)
      else $error("Status rose before the power-on delay");
   restart_drop_a: assert property (restartHeld |-> ##[0:4] linkQuiet)
      else $error("Restart left status or user mode up");
   done_after_all_a: assert property ($rose(loadComplete) |->
      wordCount == IMAGE_LAST_COUNT)
      else $error("Load complete before the whole image");
   word_cap_a: assert property (cfgValid && cfgReady |->
      wordCount < IMAGE_WORDS)
      else $error("More words than one image");
   user_after_done_a: assert property ($rose(userIoEnable) |-> loadComplete)
      else $error("User mode without load complete");
   // An overflow error flushes a stalled word on purpose, so the hold
   // only applies while status still reports a healthy load
   valid_hold_a: assert property (cfgValid && !cfgReady &&
      restartRequestN && readyStatusN |=> cfgValid && $stable(cfgWord))
      else $error("Word dropped or changed while stalled");
   narrow_mask_a: assert property (cfgValid && !wideMode |->
      cfgWord[15:8] == 8'h00)
      else $error("Upper lines leaked in narrow mode");
   init_low_a: assert property (initCompleteEn && !userIoEnable
      && readyStatusN && restartRequestN |-> !initComplete)
      else $error("Init complete high during initialisation");
   user_quiet_a: assert property (userIoEnable && restartRequestN |->
      !cfgValid)
      else $error("Word delivered in user mode");
endmodule

bind parallel_config_loader load_checker chk (
   .clk_sys(clk_sys), .resetn(resetn), .loadClock(loadClock),
   .loadData(loadData), .restartRequestN(restartRequestN),
   .wideMode(wideMode), .readyStatusN(readyStatusN),
   .loadComplete(loadComplete), .initComplete(initComplete),
   .initCompleteEn(initCompleteEn), .userIoEnable(userIoEnable),
   .cfgWord(cfgWord), .cfgValid(cfgValid), .cfgReady(cfgReady));

// ==== dv/config_host_model.sv ====
// Behavioural configuration host driving the parallel load pins
module config_host_model (
   // Link pins
   output logic        loadClock,
   output logic [15:0] loadData,
   output logic        restartRequestN,
   input  wire logic   readyStatusN
);
   timeunit 1ns;
   timeprecision 1ps;
   // Clock stands still low between frames
   initial begin
      loadClock = 1'b0;
      loadData = 16'h0000;
      restartRequestN = 1'b1;
   end
   // Bounded wait for ready before the first word
   task automatic wait_ready();
      for (int n = 0; n < 4000 && readyStatusN !== 1'b1; n++) #40;
      #13;
   endtask
   // One word per 80 ns load clock cycle, stable around the rise
   task automatic send(input logic [15:0] w);
      loadData = w;
      #20 loadClock = 1'b1;
      #40 loadClock = 1'b0;
      // Scramble before the period ends so the next word never lands
      // in the same time step as this one
      #10 loadData = ~w; // Old value gone once hold has passed
      #10;
   endtask
   // Extra falling edges after load complete
   task automatic falls(input int n);
      repeat (n) begin
         #40 loadClock = 1'b1;
         #40 loadClock = 1'b0;
      end
   endtask
   task automatic set_restart(input logic v);
      restartRequestN = v;
   endtask
endmodule

// ==== dv/parallel_config_loader_bench.sv ====
// Self-checking bench for the parallel config loader
module parallel_config_loader_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import config_loader_pkg::*;

   logic              clk_sys = 1'b0;
   logic              resetn = 1'b0;
   logic              wideMode = 1'b1;   // Wide strap at start
   logic              cfgReady = 1'b0;
   logic              loadClock;
   logic              restartRequestN;
   logic [WORD_W-1:0] loadData;
   logic [WORD_W-1:0] cfgWord;
   logic              readyStatusN;
   logic              loadComplete;
   logic              initComplete;
   logic              initCompleteEn;
   logic              userIoEnable;
   logic              cfgValid;
   logic [WORD_W-1:0] expq[$];           // Words the sink should see
   int                fails = 0;
   int                total_checks = 0;
   int                seed = 4107;
   int                cycles = 0;
   int                stall = 0;         // Percent of sink stall cycles

   always #20 clk_sys = ~clk_sys;

   config_host_model host (.loadClock(loadClock), .loadData(loadData),
      .restartRequestN(restartRequestN), .readyStatusN(readyStatusN));

   parallel_config_loader dut (.clk_sys(clk_sys), .resetn(resetn),
      .loadClock(loadClock), .loadData(loadData),
      .restartRequestN(restartRequestN), .wideMode(wideMode),
      .readyStatusN(readyStatusN), .loadComplete(loadComplete),
      .initComplete(initComplete), .initCompleteEn(initCompleteEn),
      .userIoEnable(userIoEnable), .cfgWord(cfgWord),
      .cfgValid(cfgValid), .cfgReady(cfgReady));

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic flag(input logic got, input logic exp);
      check({15'h0000, got}, {15'h0000, exp});
   endtask

   // Narrow mode keeps only the low eight lines
   function automatic logic [15:0] expect_word(input logic [15:0] w,
                                               input logic wide);
      return wide ? w : {8'h00, w[7:0]};
   endfunction

   // Random sink stalls; never stalls forever unless asked
   always @(negedge clk_sys)
      cfgReady <= ({$random(seed)} % 100) >= stall;

   // Sink side scoreboard and run limit
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles > 20000) begin
         fails++;
         close_out();
      end else if (cfgValid === 1'b1 && cfgReady === 1'b1) begin
         flag(expq.size() != 0, 1'b1);
         if (expq.size() != 0)
            check(cfgWord, expq.pop_front());
      end
   end

   // One whole image, then the closing falls and user mode
   task automatic load_image(input logic wide, input logic opt);
      logic [15:0] w;
      host.wait_ready();
      flag(readyStatusN, 1'b1);
      for (int i = 0; i < IMAGE_WORDS; i++) begin
         w = 16'($random(seed));
         if (i == 0)
            w[OPT_INIT_BIT] = opt;
         expq.push_back(expect_word(w, wide));
         host.send(w);
         if (i == 8) begin
            flag(initComplete, !opt);
            flag(initCompleteEn, opt);
         end
         if (i < IMAGE_WORDS - 1)
            flag(loadComplete, 1'b0);
      end
      for (int n = 0; n < 300 && loadComplete !== 1'b1; n++)
         @(negedge clk_sys);
      flag(loadComplete, 1'b1);
      flag(expq.size() == 0, 1'b1);
      host.falls(1);
      repeat (10) @(negedge clk_sys);
      flag(userIoEnable, 1'b0);
      host.falls(1);
      repeat (10) @(negedge clk_sys);
      flag(userIoEnable, 1'b1);
      flag(initComplete, 1'b1);
      repeat (4) host.send(16'($random(seed)));
      host.falls(3);
      repeat (10) @(negedge clk_sys);
      flag(userIoEnable, 1'b1);
   endtask

   task automatic restart_pulse();
      host.set_restart(1'b0);
      repeat (8) @(negedge clk_sys);
      flag(readyStatusN, 1'b0);
      flag(loadComplete, 1'b0);
      flag(userIoEnable, 1'b0);
      host.set_restart(1'b1);
   endtask

   // Main sequence
   initial begin
      repeat (12) @(negedge clk_sys);
      resetn <= 1'b1;
      repeat (POR_CYCLES - 100) @(negedge clk_sys);
      flag(readyStatusN, 1'b0);
      flag(loadComplete, 1'b0);
      stall = 30;
      load_image(1'b1, 1'b1);
      wideMode <= 1'b0;
      restart_pulse();
      load_image(1'b0, 1'b0);
      restart_pulse();
      host.wait_ready();
      stall = 100;
      repeat (48) host.send(16'($random(seed)));
      repeat (10) @(negedge clk_sys);
      flag(readyStatusN, 1'b0);
      restart_pulse();
      close_out();
   end
endmodule
